// >>> logic/stx_exec.sv
// Execution unit for skip, table read and exclusive-OR instructions
//
// Overview of operation
// - Byte-zero skip skips next instruction when operand is zero; flags untouched.
// - A taken skip costs two machine cycles, with a dummy slot inserted.
// - Copy-and-skip loads operand into the working register, skips if zero.
// - Bit-test skip skips only when the selected operand bit is zero.
// - Current-page table read: low byte to memory, high byte to table high register.
// - Last-page table read does the same within the final program page.
// - Register XOR stores working register XOR operand in working register; zero flag only.
// - Memory XOR writes working register XOR operand back to memory; zero flag only.
// - Immediate XOR stores working register XOR constant in working register; zero flag only.
`timescale 1ns/10ps
`default_nettype none
`include "stx_regs.svh"

module stx_exec
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Decoded instruction from fetch/decode
  input  wire logic                      instr_valid,
  input  wire stx_pkg::stx_op_t          instr_op,
  input  wire logic [2:0]                bit_sel,
  input  wire logic [`STX_DATA_W-1:0]    imm_data,
  input  wire logic [`STX_DADDR_W-1:0]   mem_addr,
  input  wire logic [`STX_DATA_W-1:0]    mem_rdata,
  input  wire logic [`STX_PADDR_W-1:0]   cur_pc,
  // Table pointer and program memory
  input  wire logic [`STX_PAGE_W-1:0]    table_pointer,
  output logic                           prog_rd,
  output logic [`STX_PADDR_W-1:0]        prog_addr,
  input  wire logic [15:0]               prog_rdata,
  // Data memory write port
  output logic                           mem_we,
  output logic [`STX_DADDR_W-1:0]        mem_waddr,
  output logic [`STX_DATA_W-1:0]         mem_wdata,
  // Core state and control
  output logic [`STX_DATA_W-1:0]         acc,
  output logic                           zero_flag,
  output logic [`STX_DATA_W-1:0]         table_high_byte_reg,
  output logic                           skip_next,
  output logic                           stall
);
  import stx_pkg::*;

  stx_state_t                 state_q, state_d;
  logic [`STX_DATA_W-1:0]     acc_q, acc_d;
  logic                       zero_q, zero_d;
  logic [`STX_DATA_W-1:0]     tbh_q, tbh_d;
  logic                       we_q, we_d;
  logic [`STX_DADDR_W-1:0]    waddr_q, waddr_d;
  logic [`STX_DATA_W-1:0]     wdata_q, wdata_d;
  logic [`STX_DADDR_W-1:0]    taddr_q;

  function automatic logic is_nil(input logic [`STX_DATA_W-1:0] v);
    return v == `STX_ZERO_BYTE;
  endfunction

  wire logic                     idle       = (state_q == STX_ST_IDLE);
  wire logic                     go         = idle && instr_valid;
  wire logic                     op_sz      = instr_op == STX_OP_SKIP_IF_BYTE_NIL;
  wire logic                     op_sza     = instr_op == STX_OP_COPY_THEN_SKIP_IF_NIL;
  wire logic                     op_szb     = instr_op == STX_OP_SKIP_IF_BIT_NIL;
  wire logic                     op_tcur    = instr_op == STX_OP_TABLE_READ_CURRENT_PAGE;
  wire logic                     op_tlast   = instr_op == STX_OP_TABLE_READ_LAST_PAGE;
  wire logic                     op_xa      = instr_op == STX_OP_XOR_TO_ACC;
  wire logic                     op_xm      = instr_op == STX_OP_EXCLUSIVE_OR_TO_MEMORY;
  wire logic                     op_xi      = instr_op == STX_OP_XOR_IMMEDIATE;
  wire logic                     byte_nil   = is_nil(mem_rdata);
  wire logic                     bit_nil    = ~mem_rdata[bit_sel];
  // Skip decision for all three skip forms
  wire logic                     skip_take  = go && (((op_sz || op_sza) && byte_nil)
                                                     || (op_szb && bit_nil));
  wire logic [`STX_DATA_W-1:0]   xor_src    = op_xi ? imm_data : mem_rdata;
  wire logic [`STX_DATA_W-1:0]   xor_res    = acc_q ^ xor_src;
  wire logic                     is_xor     = op_xa || op_xm || op_xi;
  // Page bits come from the PC or are forced to the final page
  wire logic [4:0]               page_sel   = op_tlast ? `STX_LAST_PAGE
                                                       : cur_pc[`STX_PADDR_W-1:`STX_PAGE_W];
  wire logic                     tbl_start  = go && (op_tcur || op_tlast);

  // Program address is combinational so the word returns one cycle later
  assign prog_rd   = tbl_start;
  assign prog_addr = {page_sel, table_pointer};
  // Dummy slot after a taken skip, second cycle of a table read
  assign stall     = !idle;
  assign skip_next = skip_take;

  always_comb
  begin
    state_d = state_q;
    acc_d   = acc_q;
    zero_d  = zero_q;
    tbh_d   = tbh_q;
    we_d    = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    unique case (state_q)
      STX_ST_IDLE:
      begin
        if (skip_take)
          state_d = STX_ST_DUMMY;
        if (go && op_sza)
          acc_d = mem_rdata;
        if (go && is_xor)
        begin
          zero_d = is_nil(xor_res);
          if (op_xm)
          begin
            we_d    = 1'b1;
            waddr_d = mem_addr;
            wdata_d = xor_res;
          end
          else
            acc_d = xor_res;
        end
        if (tbl_start)
          state_d = STX_ST_TABLE;
      end
      STX_ST_DUMMY:
        state_d = STX_ST_IDLE;
      STX_ST_TABLE:
      begin
        // Table read also takes two cycles: program memory is a second port access
        we_d    = 1'b1;
        waddr_d = taddr_q;
        wdata_d = prog_rdata[7:0];
        tbh_d   = prog_rdata[15:8];
        state_d = STX_ST_IDLE;
      end
      default:
        state_d = STX_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= STX_ST_IDLE;
      acc_q   <= `STX_ZERO_BYTE;
      zero_q  <= 1'b0;
      tbh_q   <= `STX_ZERO_BYTE;
      we_q    <= 1'b0;
      waddr_q <= '0;
      wdata_q <= `STX_ZERO_BYTE;
      taddr_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      acc_q   <= acc_d;
      zero_q  <= zero_d;
      tbh_q   <= tbh_d;
      we_q    <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      if (tbl_start)
        taddr_q <= mem_addr;
    end
  end

  assign acc                 = acc_q;
  assign zero_flag           = zero_q;
  assign table_high_byte_reg = tbh_q;
  assign mem_we              = we_q;
  assign mem_waddr           = waddr_q;
  assign mem_wdata           = wdata_q;

  property p_skip_byte;
    @(posedge clk) disable iff (sys_rst)
      (idle && instr_valid && (op_sz || op_sza)) |-> (skip_next == (mem_rdata == `STX_ZERO_BYTE));
  endproperty
  a_skip_byte: assert property (p_skip_byte) else $error("byte skip wrong");

  sequence s_skip;
    idle && skip_next;
  endsequence
  property p_skip_two;
    @(posedge clk) disable iff (sys_rst)
      s_skip |=> stall ##1 !stall;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("skip not two cycles");

  property p_copy;
    @(posedge clk) disable iff (sys_rst)
      (go && op_sza) |=> (acc == $past(mem_rdata)) && (zero_flag == $past(zero_flag));
  endproperty
  a_copy: assert property (p_copy) else $error("copy skip wrong");

  property p_bit;
    @(posedge clk) disable iff (sys_rst)
      (go && op_szb) |-> (skip_next == !mem_rdata[bit_sel]);
  endproperty
  a_bit: assert property (p_bit) else $error("bit skip wrong");

  // Program word lands two edges after the read starts, at the captured address
  sequence s_tbl_land;
    mem_we && (mem_wdata == $past(prog_rdata[7:0]))
      && (table_high_byte_reg == $past(prog_rdata[15:8]))
      && (mem_waddr == $past(mem_addr, 2));
  endsequence
  property p_tcur;
    @(posedge clk) disable iff (sys_rst)
      (go && op_tcur) |-> (prog_addr[`STX_PADDR_W-1:`STX_PAGE_W] == cur_pc[`STX_PADDR_W-1:`STX_PAGE_W])
        ##2 s_tbl_land;
  endproperty
  a_tcur: assert property (p_tcur) else $error("current page read wrong");

  property p_tlast;
    @(posedge clk) disable iff (sys_rst)
      (go && op_tlast) |-> (prog_addr[`STX_PADDR_W-1:`STX_PAGE_W] == `STX_LAST_PAGE) ##2 s_tbl_land;
  endproperty
  a_tlast: assert property (p_tlast) else $error("last page read wrong");

  property p_xa;
    @(posedge clk) disable iff (sys_rst)
      (go && (op_xa || op_xi)) |=> acc == ($past(acc) ^ $past(xor_src));
  endproperty
  a_xa: assert property (p_xa) else $error("xor to acc wrong");

  property p_xm;
    @(posedge clk) disable iff (sys_rst)
      (go && op_xm) |=> mem_we && mem_wdata == ($past(acc) ^ $past(mem_rdata)) && acc == $past(acc);
  endproperty
  a_xm: assert property (p_xm) else $error("xor to memory wrong");

  property p_zf;
    @(posedge clk) disable iff (sys_rst)
      (go && is_xor) |=> zero_flag == (($past(acc) ^ $past(xor_src)) == `STX_ZERO_BYTE);
  endproperty
  a_zf: assert property (p_zf) else $error("zero flag wrong");

endmodule // stx_exec
`default_nettype wire

// >>> logic/stx_pkg.sv
// Types for the skip, table read and exclusive-OR execution unit
package stx_pkg;
  typedef enum logic [3:0]
  {
    STX_OP_NONE                    = 4'h0,
    STX_OP_SKIP_IF_BYTE_NIL        = 4'h1,
    STX_OP_COPY_THEN_SKIP_IF_NIL   = 4'h2,
    STX_OP_SKIP_IF_BIT_NIL         = 4'h3,
    STX_OP_TABLE_READ_CURRENT_PAGE = 4'h4,
    STX_OP_TABLE_READ_LAST_PAGE    = 4'h5,
    STX_OP_XOR_TO_ACC              = 4'h6,
    STX_OP_EXCLUSIVE_OR_TO_MEMORY  = 4'h7,
    STX_OP_XOR_IMMEDIATE           = 4'h8
  } stx_op_t;

  typedef enum logic [1:0]
  {
    STX_ST_IDLE  = 2'b00,
    STX_ST_DUMMY = 2'b01,
    STX_ST_TABLE = 2'b10
  } stx_state_t;
endpackage

// >>> logic/stx_regs.svh
// Constants for the skip, table read and exclusive-OR execution unit
`ifndef STX_REGS_SVH
`define STX_REGS_SVH
`define STX_DATA_W       8
`define STX_PADDR_W      13
`define STX_DADDR_W      12
`define STX_PAGE_W       8
`define STX_ZERO_BYTE    8'h00
`define STX_LAST_PAGE    5'h1F
`define STX_SKIP_CYCLES  2
`endif

// >>> tb/skip_table_xor_instructions_tb.sv
// Self-checking bench for the skip, table read and exclusive-OR execution unit
`timescale 1ns/10ps
`default_nettype none
`include "stx_regs.svh"

module skip_table_xor_instructions_tb;
  import stx_pkg::*;
  logic                     clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0;
  stx_op_t                  instr_op = STX_OP_NONE;
  logic [2:0]               bit_sel = 3'h0;
  logic [`STX_DATA_W-1:0]   imm_data = 8'h00, mem_rdata = 8'h00, acc, mem_wdata, table_high_byte_reg;
  logic [`STX_DADDR_W-1:0]  mem_addr = 12'h000, mem_waddr;
  logic [`STX_PADDR_W-1:0]  cur_pc = 13'h0000, prog_addr;
  logic [`STX_PAGE_W-1:0]   table_pointer = 8'h00;
  logic [15:0]              prog_rdata = 16'h0000;
  logic                     prog_rd, mem_we, zero_flag, skip_next, stall;
  int                       err_count = 0, n_checks = 0;
  logic [7:0]               m_acc = 8'h00;
  logic                     m_zf = 1'b0;

  always #5 clk = ~clk;

  stx_exec dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_op(instr_op), .bit_sel(bit_sel),
    .imm_data(imm_data), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .cur_pc(cur_pc), .table_pointer(table_pointer),
    .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_rdata(prog_rdata), .mem_we(mem_we), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .acc(acc), .zero_flag(zero_flag), .table_high_byte_reg(table_high_byte_reg),
    .skip_next(skip_next), .stall(stall));

  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Inputs change 1 ns after the edge, each written once per edge: a task that
  // leaves instr_valid high is followed at once by the next instruction
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic go(input stx_op_t op, input logic [11:0] a, input logic [7:0] m, input logic [2:0] b,
                    input logic [7:0] imm);
    instr_op = op; mem_addr = a; mem_rdata = m; bit_sel = b; imm_data = imm; instr_valid = 1'b1;
    #1;
  endtask

  task automatic t_skip(input stx_op_t op, input logic [7:0] m, input logic [2:0] b, input logic exp);
    go(op, 12'h2C4, m, b, 8'h00);
    chk_bit("skip_next", exp, skip_next);
    tick();
    if (op == STX_OP_COPY_THEN_SKIP_IF_NIL)
      m_acc = m;
    chk_val("acc", {8'h00, m_acc}, {8'h00, acc});
    chk_bit("stall", exp, stall);
    // An instruction offered in the dummy slot must be dropped
    if (exp)
      go(STX_OP_XOR_IMMEDIATE, 12'h2C4, 8'h00, 3'h0, 8'hFF);
    else
    begin
      instr_valid = 1'b0;
      mem_rdata   = ~m;
    end
    tick();
    chk_bit("stall end", 1'b0, stall);
    chk_val("acc kept", {8'h00, m_acc}, {8'h00, acc});
    chk_bit("zero_flag kept", m_zf, zero_flag);
    $display("test skip op %0d operand %h done", op, m);
  endtask

  task automatic t_xor(input stx_op_t op, input logic [7:0] m, input logic [7:0] imm);
    logic [7:0] r;
    r = m_acc ^ ((op == STX_OP_XOR_IMMEDIATE) ? imm : m);
    go(op, 12'h9A1, m, 3'h0, imm);
    tick();
    chk_bit("mem_we", op == STX_OP_EXCLUSIVE_OR_TO_MEMORY, mem_we);
    if (op == STX_OP_EXCLUSIVE_OR_TO_MEMORY)
    begin
      chk_val("mem_waddr", 16'h09A1, {4'h0, mem_waddr});
      chk_val("mem_wdata", {8'h00, r}, {8'h00, mem_wdata});
    end
    else
      m_acc = r;
    chk_val("acc", {8'h00, m_acc}, {8'h00, acc});
    m_zf = (r == 8'h00);
    chk_bit("zero_flag", m_zf, zero_flag);
    $display("test xor op %0d result %h done", op, r);
  endtask

  task automatic t_tab(input stx_op_t op, input logic [12:0] pc, input logic [7:0] tp, input logic [15:0] w);
    logic [4:0] pg;
    pg = (op == STX_OP_TABLE_READ_LAST_PAGE) ? `STX_LAST_PAGE : pc[12:8];
    cur_pc = pc;
    table_pointer = tp;
    go(op, 12'h7F0, 8'h00, 3'h0, 8'h00);
    chk_bit("prog_rd", 1'b1, prog_rd);
    chk_val("prog_addr", {3'h0, pg, tp}, {3'h0, prog_addr});
    tick();
    chk_bit("stall", 1'b1, stall);
    prog_rdata = w;
    tick();
    // Held high through the stall, so a wrongly taken retry would show at the end
    prog_rdata = ~w;
    instr_valid = 1'b0;
    chk_bit("mem_we", 1'b1, mem_we);
    chk_val("mem_waddr", 16'h07F0, {4'h0, mem_waddr});
    chk_val("mem_wdata", {8'h00, w[7:0]}, {8'h00, mem_wdata});
    chk_val("table_high", {8'h00, w[15:8]}, {8'h00, table_high_byte_reg});
    chk_bit("zero_flag kept", m_zf, zero_flag);
    tick();
    chk_bit("mem_we end", 1'b0, mem_we);
    $display("test table op %0d word %h done", op, w);
  endtask

  // Reset held three edges clears core state; an instruction offered under it is ignored
  task automatic t_reset();
    sys_rst = 1'b1;
    go(STX_OP_XOR_IMMEDIATE, 12'h000, 8'h00, 3'h0, 8'h5A);
    tick();
    instr_valid = 1'b0;
    repeat (2) tick();
    sys_rst = 1'b0;
    m_acc = 8'h00;
    m_zf  = 1'b0;
    chk_val("acc reset", 16'h0000, {8'h00, acc});
    chk_bit("zero_flag reset", 1'b0, zero_flag);
    chk_val("table_high reset", 16'h0000, {8'h00, table_high_byte_reg});
    chk_bit("stall reset", 1'b0, stall);
    chk_bit("mem_we reset", 1'b0, mem_we);
    $display("test reset done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Whole sequence needs well under 200 cycles
  initial
  begin
    #20000;
    err_count++;
    summarize();
  end

  initial
  begin
    t_reset();
    t_skip(STX_OP_SKIP_IF_BYTE_NIL, 8'h00, 3'h0, 1'b1);
    t_skip(STX_OP_SKIP_IF_BYTE_NIL, 8'h40, 3'h0, 1'b0);
    t_skip(STX_OP_COPY_THEN_SKIP_IF_NIL, 8'h5A, 3'h0, 1'b0);
    t_xor(STX_OP_XOR_TO_ACC, 8'h5A, 8'h00);
    t_skip(STX_OP_COPY_THEN_SKIP_IF_NIL, 8'h00, 3'h0, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      t_skip(STX_OP_SKIP_IF_BIT_NIL, 8'hFF ^ (8'h01 << i), i[2:0], 1'b1);
      t_skip(STX_OP_SKIP_IF_BIT_NIL, 8'h01 << i, i[2:0], 1'b0);
    end
    t_xor(STX_OP_XOR_TO_ACC, 8'h0F, 8'h00);
    t_xor(STX_OP_EXCLUSIVE_OR_TO_MEMORY, 8'h0F, 8'h00);
    t_xor(STX_OP_XOR_IMMEDIATE, 8'h00, 8'hF0);
    t_xor(STX_OP_EXCLUSIVE_OR_TO_MEMORY, 8'h3C, 8'h00);
    t_xor(STX_OP_XOR_IMMEDIATE, 8'h00, 8'hFF);
    t_skip(STX_OP_COPY_THEN_SKIP_IF_NIL, 8'h77, 3'h0, 1'b0);
    t_tab(STX_OP_TABLE_READ_CURRENT_PAGE, 13'h0A55, 8'h33, 16'hBEEF);
    t_tab(STX_OP_TABLE_READ_LAST_PAGE, 13'h0355, 8'hC1, 16'h1200);
    t_reset();
    t_xor(STX_OP_XOR_IMMEDIATE, 8'h00, 8'h3C);
    summarize();
  end
endmodule // skip_table_xor_instructions_tb

`default_nettype wire
